// ### dv/krd_chk.sv
// Concurrent checks on the key request decoder ports
module krd_chk
   import krd_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic deriv_valid,
   input wire logic request_fault,
   input wire logic [KRD_NKEYS-1:0] key_selector,
   input wire krd_incl_t deriv_include,
   input wire logic [15:0] vendor_security_version,
   input wire logic [7:0] control_flow_attr_mask,
   input wire logic [127:0] feature_flag_mask,
   input wire logic [255:0] wear_out_nonce,
   input wire logic [15:0] config_security_version
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wp_reg;
   logic [ADDR_W-1:0] wa_reg;
   logic [31:0] w0_reg, w1_reg, w19_reg;
   logic [8:0] ptr_reg;
   logic cap_reg;
   logic st;

   // Start seen in the data phase of a control write
   assign st = wp_reg && ce && wa_reg == ADDR_W'(KRD_CTRL_OFF) && hwdata[0];

   ////////////////////////////////////////////////////////////////////////
   // Shadow of what software wrote, so outputs can be judged
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wp_reg <= 1'b0;
         wa_reg <= '0;
         w0_reg <= '0;
         w1_reg <= '0;
         w19_reg <= '0;
         ptr_reg <= '0;
         cap_reg <= 1'b0;
      end else if (ce) begin
         wp_reg <= hsel && hready && hwrite && htrans == KRD_HTRANS_NONSEQ;
         wa_reg <= haddr;
         if (wp_reg) begin
            if (wa_reg == ADDR_W'(12'h000)) w0_reg <= hwdata;
            if (wa_reg == ADDR_W'(12'h004)) w1_reg <= hwdata;
            if (wa_reg == ADDR_W'(12'h04c)) w19_reg <= hwdata;
            if (wa_reg == ADDR_W'(KRD_PTR_LO_OFF)) ptr_reg <= hwdata[8:0];
            if (wa_reg == ADDR_W'(KRD_CTRL_OFF)) begin
               cap_reg <= hwdata[KRD_CTRL_CFCAP];
               // Clear wipes the window, so the shadow follows
               if (hwdata[KRD_CTRL_CLEAR]) begin
                  w0_reg <= '0;
                  w1_reg <= '0;
                  w19_reg <= '0;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_key_decode:
      assert property (deriv_valid |-> w0_reg[15:3] == 13'h0000 &&
         key_selector == 5'(1 << w0_reg[2:0])) else $error("bad key");
   a_policy_incl:
      assert property (deriv_valid |-> deriv_include ==
         {w0_reg[21:19], ~w0_reg[18], w0_reg[17:16]}) else $error("bad incl");
   a_vendor_svn:
      assert property (deriv_valid |-> vendor_security_version ==
         w1_reg[15:0]) else $error("bad vendor version");
   a_cf_mask:
      assert property (deriv_valid |-> control_flow_attr_mask ==
         (cap_reg ? w1_reg[23:16] : 8'h00)) else $error("bad cf mask");
   a_config_svn:
      assert property (deriv_valid |-> w19_reg[31:16] == 16'h0000 &&
         config_security_version == w19_reg[15:0]) else $error("bad cfg svn");
   a_answer_time:
      assert property (st |-> ##2 (deriv_valid ^ request_fault))
         else $error("no answer two cycles after start");
   a_misalign_fault:
      assert property (st && ptr_reg != 9'h000 |-> ##2 request_fault &&
         !deriv_valid) else $error("misaligned pointer accepted");
   a_fields_hold:
      assert property (!deriv_valid |-> $stable(wear_out_nonce) &&
         $stable(feature_flag_mask)) else $error("fields moved");
   a_fault_cause:
      assert property ($rose(request_fault) |-> $past(st, 2))
         else $error("fault without start");
endmodule : krd_chk

// ### dv/krd_top_test.sv
// Self-checking bench for the key request decoder
module krd_top_test
   import krd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [15:0] sel;
      logic [15:0] pol;
      logic [7:0] cf;
      logic cap;
      logic [31:0] ptr;
      logic flt;
   } krd_row_t;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic ce = 1'b1;
   logic [31:0] hwdata = 32'h0;
   logic hrdy, hresp, dv, flt;
   logic [31:0] hrdata, rd, xmask;
   logic [4:0] key;
   krd_incl_t inc;
   logic [15:0] vsvn, csvn;
   logic [7:0] cfm;
   logic [127:0] psvn, fmask;
   logic [255:0] nonce;
   logic [31:0] wd [20];
   krd_fields_t ex = '0;
   int errors = 0;
   int tests_run = 0;
   // Ordinary cases: selector, policy, byte 6, capability, pointer, fault
   krd_row_t rows [10] = '{
      '{16'h0, 16'h1, 8'h0, 1'b0, 32'h200, 1'b0},
      '{16'h1, 16'h2, 8'h0, 1'b0, 32'h10000, 1'b0},
      '{16'h2, 16'h4, 8'h0, 1'b1, 32'h0, 1'b0},
      '{16'h3, 16'h8, 8'h5a, 1'b1, 32'h400, 1'b0},
      '{16'h4, 16'h3f, 8'hff, 1'b1, 32'h200, 1'b0},
      '{16'h5, 16'h1, 8'h0, 1'b0, 32'h200, 1'b1},
      '{16'h4, 16'h40, 8'h0, 1'b0, 32'h200, 1'b1},
      '{16'h3, 16'h30, 8'h1, 1'b0, 32'h200, 1'b1},
      '{16'h1, 16'h10, 8'h0, 1'b0, 32'h100, 1'b1},
      '{16'h2, 16'h0, 8'h0, 1'b0, 32'h0, 1'b0}};

   always #10 clk_sys = ~clk_sys;

   krd_top #(.ADDR_W(12)) dut_u (
      .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
      .hrdata(hrdata), .deriv_valid(dv), .request_fault(flt),
      .key_selector(key), .deriv_include(inc),
      .vendor_security_version(vsvn), .control_flow_attr_mask(cfm),
      .processor_security_version(psvn), .feature_flag_mask(fmask),
      .wear_out_nonce(nonce), .extended_state_mask(xmask),
      .config_security_version(csvn));

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [255:0] e,
      input logic [255:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Ready is judged mid-cycle so the edge that samples it is never raced
   task automatic wait_rdy;
      logic r;
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         r = hrdy;
         rd = hrdata;
         @(posedge clk_sys);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) begin
         errors++;
         $display("[ERR] hready expected 1 seen %b", r);
         tally_and_finish();
      end
   endtask : wait_rdy

   task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= KRD_HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      chk("hresp", 1'b0, hresp);
   endtask : bus

   task automatic set_exp(input logic cap);
      ex.key_onehot = 5'(1 << wd[0][2:0]);
      ex.incl = {wd[0][21:19], ~wd[0][18], wd[0][17:16]};
      ex.vendor_svn = wd[1][15:0];
      ex.cf_mask = cap ? wd[1][23:16] : 8'h00;
      for (int i = 0; i < 4; i++) begin
         ex.proc_svn[32*i +: 32] = wd[2 + i];
         ex.feature_mask[32*i +: 32] = wd[6 + i];
      end
      for (int i = 0; i < 8; i++) ex.nonce[32*i +: 32] = wd[10 + i];
      ex.ext_mask = wd[18];
      ex.config_svn = wd[19][15:0];
   endtask : set_exp

   // A faulting request must leave every field as the last clean one left it
   task automatic chk_out(input logic f, input logic v);
      chk("fault", f, flt);
      chk("valid", v, dv);
      chk("key", ex.key_onehot, key);
      chk("inc01", ex.incl[1:0], inc[1:0]);
      chk("inc23", ex.incl[3:2], inc[3:2]);
      chk("inc45", ex.incl[5:4], inc[5:4]);
      chk("vsvn", ex.vendor_svn, vsvn);
      chk("cfm", ex.cf_mask, cfm);
      chk("psvn", ex.proc_svn, psvn);
      chk("fmask", ex.feature_mask, fmask);
      chk("nonce", ex.nonce, nonce);
      chk("xmask", ex.ext_mask, xmask);
      chk("csvn", ex.config_svn, csvn);
   endtask : chk_out

   task automatic run_req(input logic [31:0] p, input logic c, input logic f);
      @(posedge clk_sys);
      for (int i = 0; i < 20; i++) bus(12'(4 * i), 1'b1, wd[i]);
      bus(KRD_PTR_LO_OFF, 1'b1, p);
      bus(KRD_CTRL_OFF, 1'b1, {29'h0, c, 2'b01});
      @(negedge clk_sys);
      @(negedge clk_sys);
      if (!f) set_exp(c);
      chk_out(f, !f);
   endtask : run_req

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(negedge clk_sys);
      chk_out(1'b0, 1'b0);
      foreach (rows[r]) begin
         wd[0] = {rows[r].pol, rows[r].sel};
         wd[1] = {8'h00, rows[r].cf, 16'(r * 257 + 7)};
         for (int i = 2; i < 19; i++) wd[i] = {8'(r), 8'(i), 16'ha55a};
         wd[19] = {16'h0000, 16'(r) ^ 16'hc0de};
         run_req(rows[r].ptr, rows[r].cap, rows[r].flt);
      end
      // Reserved bytes 7 and 78-79 each fault on their own
      wd[1][31:24] = 8'h01;
      run_req(32'h200, 1'b0, 1'b1);
      wd[1][31:24] = 8'h00;
      wd[19][31:16] = 16'h8000;
      run_req(32'h200, 1'b0, 1'b1);
      wd[19][31:16] = 16'h0000;
      // Stray word past the stored part poisons the request until cleared
      @(posedge clk_sys);
      bus(12'h078, 1'b1, 32'h1);
      run_req(32'h200, 1'b0, 1'b1);
      @(posedge clk_sys);
      bus(12'h078, 1'b0, 32'h0);
      chk("win30", 32'h0, rd);
      bus(KRD_STATUS_OFF, 1'b0, 32'h0);
      chk("status", 10'h103, rd[9:0]);
      bus(12'h004, 1'b0, 32'h0);
      chk("win1", wd[1], rd);
      bus(KRD_CTRL_OFF, 1'b1, 32'h2);
      bus(12'h000, 1'b0, 32'h0);
      chk("cleared", 32'h0, rd);
      bus(12'h300, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      run_req(32'h200, 1'b0, 1'b0);
      // Clock enable low freezes the block: the write must be lost
      @(posedge clk_sys);
      ce <= 1'b0;
      bus(KRD_PTR_LO_OFF, 1'b1, 32'h1);
      ce <= 1'b1;
      bus(KRD_PTR_LO_OFF, 1'b0, 32'h0);
      chk("ce_hold", 32'h200, rd);
      // Reset in mid-run returns every output except hreadyout to zero
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(negedge clk_sys);
      ex = '0;
      chk_out(1'b0, 1'b0);
      tally_and_finish();
   end
endmodule : krd_top_test

bind krd_top krd_chk #(.ADDR_W(ADDR_W)) chk_u (
   .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .deriv_valid(deriv_valid),
   .request_fault(request_fault), .key_selector(key_selector),
   .deriv_include(deriv_include),
   .vendor_security_version(vendor_security_version),
   .control_flow_attr_mask(control_flow_attr_mask),
   .feature_flag_mask(feature_flag_mask), .wear_out_nonce(wear_out_nonce),
   .config_security_version(config_security_version));

// ### pkg/krd_dec_if.sv
// Carrier between the register block and the field decoder
interface krd_dec_if;
   import krd_pkg::*;
   logic [31:0] word [0:KRD_NWORDS-1];
   logic [63:0] req_ptr;
   logic cf_capable;
   logic rsvd_window;
   krd_fields_t fields;
   modport regs (output word, req_ptr, cf_capable, rsvd_window,
      input fields);
   modport dec (input word, req_ptr, cf_capable, rsvd_window,
      output fields);
endinterface : krd_dec_if

// ### pkg/krd_pkg.sv
// Constants, types and register map of the key request decoder
package krd_pkg;
   // Register map (byte addresses)
   localparam logic [11:0] KRD_WIN_BASE = 12'h000;
   localparam logic [11:0] KRD_WIN_LAST = 12'h1fc;
   localparam logic [11:0] KRD_CTRL_OFF = 12'h200;
   localparam logic [11:0] KRD_PTR_LO_OFF = 12'h204;
   localparam logic [11:0] KRD_PTR_HI_OFF = 12'h208;
   localparam logic [11:0] KRD_STATUS_OFF = 12'h20c;
   localparam logic [11:0] KRD_SEL_OFF = 12'h210;
   // Stored part of the request: bytes 0..79
   localparam int KRD_NWORDS = 20;
   localparam int KRD_IDX_W = 7;
   localparam logic [6:0] KRD_LAST_STORED = 7'h13;
   // Word index of each field
   localparam int KRD_W_HEAD = 0;
   localparam int KRD_W_VSVN = 1;
   localparam int KRD_W_PSVN = 2;
   localparam int KRD_W_FMASK = 6;
   localparam int KRD_W_NONCE = 10;
   localparam int KRD_W_XMASK = 18;
   localparam int KRD_W_CSVN = 19;
   localparam int KRD_PSVN_N = 4;
   localparam int KRD_FMASK_N = 4;
   localparam int KRD_NONCE_N = 8;
   // Alignment of the request structure
   localparam int KRD_ALIGN_BITS = 9;
   // Key selector codes
   localparam int KRD_NKEYS = 5;
   localparam logic [15:0] KRD_KEY_LAUNCH_TOKEN = 16'h0000;
   localparam logic [15:0] KRD_KEY_PROV = 16'h0001;
   localparam logic [15:0] KRD_KEY_PROV_SEAL = 16'h0002;
   localparam logic [15:0] KRD_KEY_REPORT = 16'h0003;
   localparam logic [15:0] KRD_KEY_SEAL = 16'h0004;
   // Policy bit positions
   localparam int KRD_POL_CODE = 0;
   localparam int KRD_POL_SIGNER = 1;
   localparam int KRD_POL_NO_PROD = 2;
   localparam int KRD_POL_CONFIG = 3;
   localparam int KRD_POL_FAMILY = 4;
   localparam int KRD_POL_EXTPROD = 5;
   localparam logic [15:0] KRD_POL_RSVD_MASK = 16'hffc0;
   // Control bits
   localparam int KRD_CTRL_START = 0;
   localparam int KRD_CTRL_CLEAR = 1;
   localparam int KRD_CTRL_CFCAP = 2;
   // Status fields
   localparam int KRD_ST_DONE = 0;
   localparam int KRD_ST_FAULT = 1;
   localparam int KRD_ST_CAUSE = 4;
   localparam int KRD_SEL_INCL = 8;
   localparam logic [1:0] KRD_HTRANS_NONSEQ = 2'h2;

   // Fault causes
   typedef struct packed {
      logic cf_nonzero;
      logic rsvd_window;
      logic rsvd_bytes;
      logic rsvd_policy;
      logic bad_selector;
      logic misaligned;
   } krd_cause_t;

   // Include flags for the derivation inputs
   typedef struct packed {
      logic ext_product;
      logic family;
      logic config_ident;
      logic product;
      logic signer;
      logic code;
   } krd_incl_t;

   typedef struct packed {
      logic [KRD_NKEYS-1:0] key_onehot;
      krd_incl_t incl;
      logic [15:0] vendor_svn;
      logic [7:0] cf_mask;
      logic [127:0] proc_svn;
      logic [127:0] feature_mask;
      logic [255:0] nonce;
      logic [31:0] ext_mask;
      logic [15:0] config_svn;
      krd_cause_t cause;
   } krd_fields_t;

   typedef enum logic [1:0] {
      KRD_IDLE = 2'b00,
      KRD_CHECK = 2'b01,
      KRD_DONE = 2'b11
   } krd_state_t;
endpackage : krd_pkg

// ### rtl/krd_decode.sv
// Combinational field extraction and checking of the key request
module krd_decode
   import krd_pkg::*;
(
   krd_dec_if.dec d
);
   logic [15:0] sel;
   logic [15:0] pol;
   logic [7:0] cf_byte;

   assign sel = d.word[KRD_W_HEAD][15:0]; // [RULE_02]
   assign pol = d.word[KRD_W_HEAD][31:16]; // [RULE_03]
   assign cf_byte = d.word[KRD_W_VSVN][23:16];

   // One decoder per key code
   genvar k;
   generate
      for (k = 0; k < KRD_NKEYS; k++) begin : g_key
         assign d.fields.key_onehot[k] = (sel == 16'(k)); // [RULE_02]
      end
      for (k = 0; k < KRD_PSVN_N; k++) begin : g_psvn
         assign d.fields.proc_svn[32*k +: 32] =
            d.word[KRD_W_PSVN+k]; // [RULE_06]
      end
      for (k = 0; k < KRD_FMASK_N; k++) begin : g_fmask
         assign d.fields.feature_mask[32*k +: 32] =
            d.word[KRD_W_FMASK+k]; // [RULE_07]
      end
      for (k = 0; k < KRD_NONCE_N; k++) begin : g_nonce
         assign d.fields.nonce[32*k +: 32] =
            d.word[KRD_W_NONCE+k]; // [RULE_08]
      end
   endgenerate

   assign d.fields.incl.code = pol[KRD_POL_CODE]; // [RULE_11]
   assign d.fields.incl.signer = pol[KRD_POL_SIGNER]; // [RULE_12]
   assign d.fields.incl.product = ~pol[KRD_POL_NO_PROD]; // [RULE_13]
   assign d.fields.incl.config_ident = pol[KRD_POL_CONFIG]; // [RULE_14]
   assign d.fields.incl.family = pol[KRD_POL_FAMILY]; // [RULE_15]
   assign d.fields.incl.ext_product = pol[KRD_POL_EXTPROD]; // [RULE_16]
   assign d.fields.vendor_svn = d.word[KRD_W_VSVN][15:0]; // [RULE_04]
   // Mask only counts when the capability is present
   assign d.fields.cf_mask = d.cf_capable ? cf_byte : 8'h00; // [RULE_05]
   assign d.fields.ext_mask = d.word[KRD_W_XMASK]; // [RULE_09]
   assign d.fields.config_svn = d.word[KRD_W_CSVN][15:0]; // [RULE_10]

   assign d.fields.cause.misaligned =
      |d.req_ptr[KRD_ALIGN_BITS-1:0]; // [RULE_01]
   assign d.fields.cause.bad_selector = (sel > KRD_KEY_SEAL); // [RULE_17]
   assign d.fields.cause.rsvd_policy = |(pol & KRD_POL_RSVD_MASK); // [RULE_17]
   assign d.fields.cause.rsvd_bytes = (|d.word[KRD_W_VSVN][31:24]) |
      (|d.word[KRD_W_CSVN][31:16]); // [RULE_17]
   assign d.fields.cause.rsvd_window = d.rsvd_window; // [RULE_17]
   assign d.fields.cause.cf_nonzero =
      ~d.cf_capable & (|cf_byte); // [RULE_05]
endmodule : krd_decode

// ### rtl/krd_top.sv
// Key request decoder: AHB-Lite register file, checks and field latches
//
// How it works
// RULE_01: software puts the request 512-byte aligned and gives its pointer.
// RULE_02: key selector at byte 0 decodes codes 0 to 4; others reserved.
// RULE_03: derivation policy is the 2-byte field at byte 2.
// RULE_04: vendor security version at byte 4 feeds the derivation.
// RULE_05: byte 6 masks control-flow attributes only when capable, else zero.
// RULE_06: 16-byte processor security version at byte 8 feeds derivation.
// RULE_07: 16-byte mask at byte 24 selects feature flag bits.
// RULE_08: 32-byte wear-out nonce at byte 40 feeds derivation.
// RULE_09: 4-byte mask at byte 72 selects extended-state selection bits.
// RULE_10: config security version at byte 76 feeds derivation.
// RULE_11: policy bit 0 includes the code measurement.
// RULE_12: policy bit 1 includes the signer measurement.
// RULE_13: policy bit 2 leaves the product identifier out.
// RULE_14: policy bit 3 includes the post-init configuration identifier.
// RULE_15: policy bit 4 includes the product family identifier.
// RULE_16: policy bit 5 includes the extended product identifier.
// RULE_17: reserved bits must be zero; bad alignment, code or content fault. Past byte 79 the code checks only the latest write, so a zero write clears it.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
module krd_top
   import krd_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic deriv_valid,
   output logic request_fault,
   output logic [KRD_NKEYS-1:0] key_selector,
   output krd_incl_t deriv_include,
   output logic [15:0] vendor_security_version,
   output logic [7:0] control_flow_attr_mask,
   output logic [127:0] processor_security_version,
   output logic [127:0] feature_flag_mask,
   output logic [255:0] wear_out_nonce,
   output logic [31:0] extended_state_mask,
   output logic [15:0] config_security_version
);
   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks: the decoder reads address bits 11..0, and the
   // read mux picks a stored word with a 5-bit index
   if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
      $error("krd_top: ADDR_W must lie in 12..32");
   end
   if (KRD_NWORDS > 32) begin : g_bad_nwords
      $error("krd_top: at most 32 stored words");
   end

   krd_dec_if dif ();
   krd_decode u_dec (.d(dif.dec));

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: writes complete without wait, reads take one wait state
   // so that a read right after a write sees the written value.
   logic [11:0] addr_reg;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic addr_ok;
   logic wr_hit;
   logic [11:0] waddr;

   // Size is ignored: every access is taken as a whole word
   assign addr_ok = hsel & hready & (htrans == KRD_HTRANS_NONSEQ);
   assign wr_hit = wr_pend_reg;
   assign waddr = addr_reg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg <= 12'h000;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
      end else if (ce) begin
         wr_pend_reg <= addr_ok & hwrite;
         rd_pend_reg <= addr_ok & ~hwrite;
         if (addr_ok) begin
            addr_reg <= haddr[11:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
      end else if (ce) begin
         // Stall the first data cycle of each read
         hreadyout <= ~(addr_ok & ~hwrite);
      end
   end

   // No error response: refused accesses still answer OKAY
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hresp <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request window: the first words are kept, the rest only checked
   logic [31:0] word_reg [0:KRD_NWORDS-1];
   logic in_window;
   logic [KRD_IDX_W-1:0] widx;
   logic start_wr;
   logic clear_wr;

   assign in_window = (waddr <= KRD_WIN_LAST);
   assign widx = waddr[KRD_IDX_W+1:2];
   assign start_wr = wr_hit & (waddr == KRD_CTRL_OFF) &
      hwdata[KRD_CTRL_START];
   assign clear_wr = wr_hit & (waddr == KRD_CTRL_OFF) &
      hwdata[KRD_CTRL_CLEAR];

   genvar i;
   generate
      for (i = 0; i < KRD_NWORDS; i++) begin : g_word
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               word_reg[i] <= 32'h0000_0000;
            end else if (ce) begin
               if (clear_wr) begin
                  word_reg[i] <= 32'h0000_0000;
               end else if (wr_hit && in_window &&
                            widx == KRD_IDX_W'(i)) begin
                  word_reg[i] <= hwdata;
               end
            end
         end
         assign dif.word[i] = word_reg[i];
      end
   endgenerate

   // Any nonzero word past the stored fields marks reserved content;
   // the flag follows the latest such write, so a zero write heals it
   logic rsvd_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rsvd_reg <= 1'b0;
      end else if (ce) begin
         if (wr_hit && in_window && widx > KRD_LAST_STORED) begin
            rsvd_reg <= (hwdata != 32'h0000_0000); // [RULE_17]
         end else if (clear_wr) begin
            rsvd_reg <= 1'b0;
         end
      end
   end
   assign dif.rsvd_window = rsvd_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pointer and capability registers
   // Only the low pointer bits decide alignment; the high word is for reads
   logic [31:0] ptr_lo_reg;
   logic [31:0] ptr_hi_reg;
   logic cfcap_reg;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ptr_lo_reg <= 32'h0000_0000;
         ptr_hi_reg <= 32'h0000_0000;
         cfcap_reg <= 1'b0;
      end else if (ce && wr_hit) begin
         if (waddr == KRD_PTR_LO_OFF) begin
            ptr_lo_reg <= hwdata; // [RULE_01]
         end
         if (waddr == KRD_PTR_HI_OFF) begin
            ptr_hi_reg <= hwdata;
         end
         if (waddr == KRD_CTRL_OFF) begin
            cfcap_reg <= hwdata[KRD_CTRL_CFCAP]; // [RULE_05]
         end
      end
   end
   assign dif.req_ptr = {ptr_hi_reg, ptr_lo_reg};
   assign dif.cf_capable = cfcap_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: start, check one cycle, publish
   // Starts that arrive while a check runs are dropped, not queued;
   // DONE gives one guard cycle before the next start is taken
   krd_state_t state_reg;
   logic fault_now;

   assign fault_now = |dif.fields.cause;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= KRD_IDLE;
      end else if (ce) begin
         case (state_reg)
            KRD_IDLE: begin
               if (start_wr) begin
                  state_reg <= KRD_CHECK;
               end
            end
            KRD_CHECK: state_reg <= KRD_DONE;
            KRD_DONE: state_reg <= KRD_IDLE;
            default: state_reg <= KRD_IDLE;
         endcase
      end
   end

   // Status: done and fault are cleared by the next start
   logic done_reg;
   krd_cause_t cause_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         done_reg <= 1'b0;
         cause_reg <= '0;
         request_fault <= 1'b0;
         deriv_valid <= 1'b0;
      end else if (ce) begin
         deriv_valid <= 1'b0;
         if (state_reg == KRD_CHECK) begin
            done_reg <= 1'b1;
            cause_reg <= dif.fields.cause;
            request_fault <= fault_now; // [RULE_17]
            deriv_valid <= ~fault_now;
         end else if (start_wr && state_reg == KRD_IDLE) begin
            done_reg <= 1'b0;
            cause_reg <= '0;
            request_fault <= 1'b0;
         end
      end
   end

   // Fields for the derivation datapath, only from a clean request
   // A fault keeps the old fields, so no half-checked mix ever leaves
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         key_selector <= '0;
         deriv_include <= '0;
         vendor_security_version <= 16'h0000;
         control_flow_attr_mask <= 8'h00;
         processor_security_version <= '0;
         feature_flag_mask <= '0;
         wear_out_nonce <= '0;
         extended_state_mask <= 32'h0000_0000;
         config_security_version <= 16'h0000;
      end else if (ce && state_reg == KRD_CHECK && !fault_now) begin
         key_selector <= dif.fields.key_onehot; // [RULE_02]
         deriv_include <= dif.fields.incl; // [RULE_11] [RULE_13]
         vendor_security_version <= dif.fields.vendor_svn; // [RULE_04]
         control_flow_attr_mask <= dif.fields.cf_mask; // [RULE_05]
         processor_security_version <= dif.fields.proc_svn; // [RULE_06]
         feature_flag_mask <= dif.fields.feature_mask; // [RULE_07]
         wear_out_nonce <= dif.fields.nonce; // [RULE_08]
         extended_state_mask <= dif.fields.ext_mask; // [RULE_09]
         config_security_version <= dif.fields.config_svn; // [RULE_10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in the stalled data cycle
   // Window words past the stored part read zero; they are only checked
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_window) begin
         if (widx <= KRD_LAST_STORED) begin
            rd_mux = word_reg[widx[4:0]];
         end
      end else begin
         case (waddr)
            KRD_CTRL_OFF: rd_mux[KRD_CTRL_CFCAP] = cfcap_reg;
            KRD_PTR_LO_OFF: rd_mux = ptr_lo_reg;
            KRD_PTR_HI_OFF: rd_mux = ptr_hi_reg;
            KRD_STATUS_OFF: begin
               rd_mux[KRD_ST_DONE] = done_reg;
               rd_mux[KRD_ST_FAULT] = request_fault;
               rd_mux[KRD_ST_CAUSE +: 6] = cause_reg;
            end
            KRD_SEL_OFF: begin
               rd_mux[KRD_NKEYS-1:0] = key_selector;
               rd_mux[KRD_SEL_INCL +: 6] = deriv_include;
            end
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && rd_pend_reg) begin
         hrdata <= rd_mux;
      end
   end
endmodule : krd_top
